// ### core/cpu_register_file.sv
// cpu register file with flags, interrupt gating, address map and bus slave
// Behaviour
// - two banks of four data, two address, frame
// - data words 16 bit, first two byte-split
// - data2:data0 and data3:data1 form 32 bits
// - address pointers pair, second is upper half
// - frame base and static base, 16 bit
// - vector table base is 20 bits
// - program counter is 20 bits
// - two 16-bit stacks, one active at once
// - flag register 11 bits with all fields
// - carry takes alu carry, borrow, shift-out
// - zero set when result is zero
// - sign set when result is negative
// - overflow set when operation overflows
// - bank bit routes banked accesses
// - enable bit masks; cleared on acknowledge
// - stack bit picks stack; cleared on hardware ints and soft ints 0-31
// - accept only priority above processor level
// - reserved flag bits written zero, read undefined
// - one megabyte space, program rom ends 0FFFFh
// - vector table 0FFDCh to 0FFFFh
// - ram starts at 00400h and grows up
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module cpu_register_file #(
	parameter int RAM_BYTES = 2560,
	parameter int ROM_BYTES = 49152
)(
	input  wire logic                   clk,         // core clock
	input  wire logic                   rst_n,       // async reset
	input  wire cpu_regs_pkg::regWr_t    wrIn,        // execution write
	input  wire cpu_regs_pkg::regSel_t   rdSel,       // execution read select
	input  wire cpu_regs_pkg::opSize_t   rdSize,      // execution read size
	output logic [31:0]                 rdData,      // execution read data
	input  wire cpu_regs_pkg::aluFlags_t aluIn,       // alu flag update
	input  wire cpu_regs_pkg::intReq_t   irqIn,       // pending request
	output logic                        irqTake,     // request may be taken
	input  wire logic                   hwAck,       // hardware int acknowledged
	input  wire logic                   swIntAck,    // software int executed
	input  wire logic [5:0]             swIntNum,    // software int number
	input  wire logic [19:0]            memAddr,     // operand address
	output cpu_regs_pkg::region_t        memRegion,   // operand region
	output cpu_regs_pkg::region_t        fetchRegion, // region of program counter
	output logic [10:0]                 flagsOut,    // flag register
	output logic [15:0]                 activeSp,    // selected stack pointer
	output logic [19:0]                 progOut,     // program counter
	output logic [19:0]                 vtbOut,      // vector table base
	input  wire logic [7:0]             awaddr,      // axi write address
	input  wire logic                   awvalid,     // axi
	output logic                        awready,     // axi
	input  wire logic [31:0]            wdata,       // axi
	input  wire logic [3:0]             wstrb,       // axi
	input  wire logic                   wvalid,      // axi
	output logic                        wready,      // axi
	output logic [1:0]                  bresp,       // axi
	output logic                        bvalid,      // axi
	input  wire logic                   bready,      // axi
	input  wire logic [7:0]             araddr,      // axi read address
	input  wire logic                   arvalid,     // axi
	output logic                        arready,     // axi
	output logic [31:0]                 rdata,       // axi
	output logic [1:0]                  rresp,       // axi
	output logic                        rvalid,      // axi
	input  wire logic                   rready       // axi
);
	localparam logic [19:0] RAM_END  = 20'(int'(cpu_regs_pkg::RAM_BASE) + RAM_BYTES - 1);
	localparam logic [19:0] ROM_BASE = 20'(int'(cpu_regs_pkg::ROM_TOP) + 1 - ROM_BYTES);

	if (RAM_BYTES < 1 || ROM_BYTES < 1 ||
		int'(RAM_END) >= int'(cpu_regs_pkg::SFR2_BASE) ||
		int'(ROM_BASE) <= int'(cpu_regs_pkg::SFR2_END)) begin : g_bad
		$error("memory sizes overlap other areas");
	end

	cpu_regs_pkg::state_t s;
	cpu_regs_pkg::state_t n;
	logic       bk;
	logic       wrBank;
	logic [5:0] wIdx;
	logic [5:0] rIdx;
	logic       wOk;

	function automatic cpu_regs_pkg::region_t decode(input logic [19:0] a);
		if (a <= cpu_regs_pkg::SFR_END ||
			(a >= cpu_regs_pkg::SFR2_BASE && a <= cpu_regs_pkg::SFR2_END))
			return cpu_regs_pkg::REGION_SFR;
		if (a >= cpu_regs_pkg::VECT_BASE) begin
			if (a <= cpu_regs_pkg::ROM_TOP)
				return cpu_regs_pkg::REGION_VECT;
			return cpu_regs_pkg::REGION_NONE;
		end
		if (a >= ROM_BASE)
			return cpu_regs_pkg::REGION_ROM;
		if (a >= cpu_regs_pkg::RAM_BASE && a <= RAM_END)
			return cpu_regs_pkg::REGION_RAM;
		return cpu_regs_pkg::REGION_NONE;
	endfunction

	function automatic logic mapped(input logic [5:0] i);
		if (i[5:4] == 2'h0)
			return i[2:0] <= cpu_regs_pkg::SLOT_FRAME;
		return i >= cpu_regs_pkg::AX_VTB && i <= cpu_regs_pkg::AX_FLAGS;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int k = 0; k < 4; k++) begin
			if (st[k])
				r[k*8 +: 8] = d[k*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [15:0] slotGet(input cpu_regs_pkg::bank_t b,
		input logic [2:0] sl);
		if (sl < cpu_regs_pkg::SLOT_ADDR)
			return b.data[sl[1:0]];
		if (sl < cpu_regs_pkg::SLOT_FRAME)
			return b.addr[sl[0]];
		return b.frame;
	endfunction

	function automatic logic [31:0] axiGet(input cpu_regs_pkg::state_t st,
		input logic [5:0] i);
		if (i[5:4] == 2'h0)
			return {16'h0000, slotGet(st.bank[i[3]], i[2:0])};
		case (i)
			cpu_regs_pkg::AX_VTB:    return {12'h000, st.vtb};
			cpu_regs_pkg::AX_PROG:   return {12'h000, st.prog};
			cpu_regs_pkg::AX_USP:    return {16'h0000, st.user_stack_ptr};
			cpu_regs_pkg::AX_ISP:    return {16'h0000, st.irq_stack_ptr};
			cpu_regs_pkg::AX_STATIC: return {16'h0000, st.stat};
			cpu_regs_pkg::AX_FLAGS:  return {21'h000000, st.flags};
			default:                 return 32'h00000000;
		endcase
	endfunction

	// execution-side read, always through the bank picked by the flag
	function automatic logic [31:0] execGet(input cpu_regs_pkg::state_t st,
		input cpu_regs_pkg::regSel_t sl, input cpu_regs_pkg::opSize_t sz);
		cpu_regs_pkg::bank_t b;
		logic                j;
		b = st.bank[st.flags[cpu_regs_pkg::FLG_B]];
		j = (sl == cpu_regs_pkg::SEL_DATA1);
		case (sl)
			cpu_regs_pkg::SEL_DATA0, cpu_regs_pkg::SEL_DATA1: begin
				case (sz)
					cpu_regs_pkg::SZ_LO:   return {24'h000000, b.data[j][7:0]};
					cpu_regs_pkg::SZ_HI:   return {24'h000000, b.data[j][15:8]};
					cpu_regs_pkg::SZ_LONG: return {b.data[{1'b1, j}], b.data[j]};
					default:               return {16'h0000, b.data[j]};
				endcase
			end
			cpu_regs_pkg::SEL_DATA2: return {16'h0000, b.data[2]};
			cpu_regs_pkg::SEL_DATA3: return {16'h0000, b.data[3]};
			cpu_regs_pkg::SEL_ADDR0: begin
				if (sz == cpu_regs_pkg::SZ_LONG)
					return {b.addr[1], b.addr[0]};
				return {16'h0000, b.addr[0]};
			end
			cpu_regs_pkg::SEL_ADDR1:  return {16'h0000, b.addr[1]};
			cpu_regs_pkg::SEL_FRAME:  return {16'h0000, b.frame};
			cpu_regs_pkg::SEL_VTB:    return {12'h000, st.vtb};
			cpu_regs_pkg::SEL_PROG:   return {12'h000, st.prog};
			cpu_regs_pkg::SEL_USP:    return {16'h0000, st.user_stack_ptr};
			cpu_regs_pkg::SEL_ISP:    return {16'h0000, st.irq_stack_ptr};
			cpu_regs_pkg::SEL_STATIC: return {16'h0000, st.stat};
			cpu_regs_pkg::SEL_FLAGS:  return {21'h000000, st.flags};
			cpu_regs_pkg::SEL_SP: begin
				if (st.flags[cpu_regs_pkg::FLG_U])
					return {16'h0000, st.user_stack_ptr};
				return {16'h0000, st.irq_stack_ptr};
			end
			default: return 32'h00000000;
		endcase
	endfunction

	assign awready = !s.awHeld && !s.bvalid;
	assign wready  = !s.wHeld && !s.bvalid;
	assign arready = !s.rvalid;

	always_comb begin
		n = s;
		bk = s.flags[cpu_regs_pkg::FLG_B];
		wIdx = s.awAddr[7:2];
		rIdx = araddr[7:2];
		wOk = mapped(wIdx);
		wrBank = wIdx[3];
		if (awvalid && awready) begin
			n.awHeld = 1'b1;
			n.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			n.wHeld = 1'b1;
			n.wData = wdata;
			n.wStrb = wstrb;
		end
		if (s.bvalid && bready)
			n.bvalid = 1'b0;
		// bus write completes once address and data are both held
		if (s.awHeld && s.wHeld && !s.bvalid) begin
			n.awHeld = 1'b0;
			n.wHeld = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wOk ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR;
			if (wIdx[5:4] == 2'h0 && wOk) begin
				if (wIdx[2:0] < cpu_regs_pkg::SLOT_ADDR)
					n.bank[wrBank].data[wIdx[1:0]] =
						16'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				else if (wIdx[2:0] < cpu_regs_pkg::SLOT_FRAME)
					n.bank[wrBank].addr[wIdx[0]] =
						16'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				else
					n.bank[wrBank].frame =
						16'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
			end
			case (wIdx)
				cpu_regs_pkg::AX_VTB:
					n.vtb = 20'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				cpu_regs_pkg::AX_PROG:
					n.prog = 20'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				cpu_regs_pkg::AX_USP:
					n.user_stack_ptr = 16'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				cpu_regs_pkg::AX_ISP:
					n.irq_stack_ptr = 16'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				cpu_regs_pkg::AX_STATIC:
					n.stat = 16'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				cpu_regs_pkg::AX_FLAGS:
					n.flags = 11'(merge(axiGet(s, wIdx), s.wData, s.wStrb));
				default: ;
			endcase
		end
		if (s.rvalid && rready)
			n.rvalid = 1'b0;
		if (arvalid && arready) begin
			n.rvalid = 1'b1;
			n.rdata = axiGet(s, rIdx);
			n.rresp = mapped(rIdx) ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR;
		end
		// execution unit overrides a same-cycle bus write to the same register
		if (wrIn.en) begin
			case (wrIn.sel)
				cpu_regs_pkg::SEL_DATA0, cpu_regs_pkg::SEL_DATA1: begin
					case (wrIn.size)
						cpu_regs_pkg::SZ_LO:
							n.bank[bk].data[wrIn.sel == cpu_regs_pkg::SEL_DATA1][7:0] =
								wrIn.data[7:0];
						cpu_regs_pkg::SZ_HI:
							n.bank[bk].data[wrIn.sel == cpu_regs_pkg::SEL_DATA1][15:8] =
								wrIn.data[7:0];
						cpu_regs_pkg::SZ_LONG: begin
							n.bank[bk].data[wrIn.sel == cpu_regs_pkg::SEL_DATA1] =
								wrIn.data[15:0];
							n.bank[bk].data[{1'b1, wrIn.sel == cpu_regs_pkg::SEL_DATA1}] =
								wrIn.data[31:16];
						end
						default:
							n.bank[bk].data[wrIn.sel == cpu_regs_pkg::SEL_DATA1] =
								wrIn.data[15:0];
					endcase
				end
				cpu_regs_pkg::SEL_DATA2: n.bank[bk].data[2] = wrIn.data[15:0];
				cpu_regs_pkg::SEL_DATA3: n.bank[bk].data[3] = wrIn.data[15:0];
				cpu_regs_pkg::SEL_ADDR0: begin
					n.bank[bk].addr[0] = wrIn.data[15:0];
					if (wrIn.size == cpu_regs_pkg::SZ_LONG)
						n.bank[bk].addr[1] = wrIn.data[31:16];
				end
				cpu_regs_pkg::SEL_ADDR1:  n.bank[bk].addr[1] = wrIn.data[15:0];
				cpu_regs_pkg::SEL_FRAME:  n.bank[bk].frame = wrIn.data[15:0];
				cpu_regs_pkg::SEL_VTB:    n.vtb = wrIn.data[19:0];
				cpu_regs_pkg::SEL_PROG:   n.prog = wrIn.data[19:0];
				cpu_regs_pkg::SEL_USP:    n.user_stack_ptr = wrIn.data[15:0];
				cpu_regs_pkg::SEL_ISP:    n.irq_stack_ptr = wrIn.data[15:0];
				cpu_regs_pkg::SEL_STATIC: n.stat = wrIn.data[15:0];
				cpu_regs_pkg::SEL_FLAGS:  n.flags = wrIn.data[10:0];
				cpu_regs_pkg::SEL_SP: begin
					if (s.flags[cpu_regs_pkg::FLG_U])
						n.user_stack_ptr = wrIn.data[15:0];
					else
						n.irq_stack_ptr = wrIn.data[15:0];
				end
				default: ;
			endcase
		end
		if (aluIn.en) begin
			n.flags[cpu_regs_pkg::FLG_C] = aluIn.carry;
			n.flags[cpu_regs_pkg::FLG_O] = aluIn.ovf;
			case (aluIn.size)
				cpu_regs_pkg::SZ_LONG: begin
					n.flags[cpu_regs_pkg::FLG_Z] = aluIn.result == 32'h00000000;
					n.flags[cpu_regs_pkg::FLG_S] = aluIn.result[31];
				end
				cpu_regs_pkg::SZ_WORD: begin
					n.flags[cpu_regs_pkg::FLG_Z] = aluIn.result[15:0] == 16'h0000;
					n.flags[cpu_regs_pkg::FLG_S] = aluIn.result[15];
				end
				default: begin
					n.flags[cpu_regs_pkg::FLG_Z] = aluIn.result[7:0] == 8'h00;
					n.flags[cpu_regs_pkg::FLG_S] = aluIn.result[7];
				end
			endcase
		end
		// acknowledge comes last so it beats any flag write in the same cycle
		if (hwAck || swIntAck)
			n.flags[cpu_regs_pkg::FLG_I] = 1'b0;
		if (hwAck || (swIntAck && swIntNum < cpu_regs_pkg::SWI_USER_LIMIT))
			n.flags[cpu_regs_pkg::FLG_U] = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign irqTake = irqIn.req &&
		irqIn.level > s.flags[cpu_regs_pkg::FLG_PRIO +: 3] &&
		(s.flags[cpu_regs_pkg::FLG_I] || !irqIn.maskable);
	assign rdData      = execGet(s, rdSel, rdSize);
	assign memRegion   = decode(memAddr);
	assign fetchRegion = decode(s.prog);
	assign flagsOut    = s.flags;
	assign activeSp    = s.flags[cpu_regs_pkg::FLG_U] ? s.user_stack_ptr : s.irq_stack_ptr;
	assign progOut     = s.prog;
	assign vtbOut      = s.vtb;
	assign bvalid      = s.bvalid;
	assign bresp       = s.bresp;
	assign rvalid      = s.rvalid;
	assign rdata       = s.rdata;
	assign rresp       = s.rresp;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_bank;
		wrIn.en && wrIn.sel == cpu_regs_pkg::SEL_DATA0 && wrIn.size == cpu_regs_pkg::SZ_WORD
		|=> s.bank[$past(s.flags[cpu_regs_pkg::FLG_B])].data[0] == $past(wrIn.data[15:0]);
	endproperty
	a_bank: assert property (p_bank) else $error("banked write misrouted");

	property p_pair;
		rdSel == cpu_regs_pkg::SEL_DATA1 && rdSize == cpu_regs_pkg::SZ_LONG |->
		rdData == {s.bank[s.flags[cpu_regs_pkg::FLG_B]].data[3],
			s.bank[s.flags[cpu_regs_pkg::FLG_B]].data[1]};
	endproperty
	a_pair: assert property (p_pair) else $error("wide pair read wrong");

	property p_ack;
		hwAck |=> !s.flags[cpu_regs_pkg::FLG_I] && !s.flags[cpu_regs_pkg::FLG_U];
	endproperty
	a_ack: assert property (p_ack) else $error("ack left enable or stack bit");

	property p_swi;
		swIntAck && !hwAck && swIntNum >= cpu_regs_pkg::SWI_USER_LIMIT && !wrIn.en &&
		!(s.awHeld && s.wHeld) && s.flags[cpu_regs_pkg::FLG_U] |=> s.flags[cpu_regs_pkg::FLG_U];
	endproperty
	a_swi: assert property (p_swi) else $error("high soft int cleared stack bit");

	property p_take;
		irqTake |-> irqIn.level > flagsOut[cpu_regs_pkg::FLG_PRIO +: 3];
	endproperty
	a_take: assert property (p_take) else $error("low priority request taken");

	property p_zero;
		aluIn.en && aluIn.size == cpu_regs_pkg::SZ_WORD |=>
		flagsOut[cpu_regs_pkg::FLG_Z] == ($past(aluIn.result[15:0]) == 16'h0000);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_sign;
		aluIn.en && aluIn.size == cpu_regs_pkg::SZ_LONG |=>
		flagsOut[cpu_regs_pkg::FLG_S] == $past(aluIn.result[31]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");

	property p_carry;
		aluIn.en |=> flagsOut[cpu_regs_pkg::FLG_C] == $past(aluIn.carry) &&
		flagsOut[cpu_regs_pkg::FLG_O] == $past(aluIn.ovf);
	endproperty
	a_carry: assert property (p_carry) else $error("carry or overflow wrong");

	property p_vect;
		memRegion == cpu_regs_pkg::REGION_VECT |->
		memAddr >= cpu_regs_pkg::VECT_BASE && memAddr <= cpu_regs_pkg::ROM_TOP;
	endproperty
	a_vect: assert property (p_vect) else $error("vector area decode wrong");

	property p_sp;
		wrIn.en && wrIn.sel == cpu_regs_pkg::SEL_SP && !hwAck && !swIntAck && !aluIn.en &&
		!(s.awHeld && s.wHeld) |=> activeSp == $past(wrIn.data[15:0]);
	endproperty
	a_sp: assert property (p_sp) else $error("active stack write lost");

	c_bank1: cover property (wrIn.en && s.flags[cpu_regs_pkg::FLG_B]);
	c_take: cover property (irqTake ##1 hwAck);
	c_write: cover property (s.bvalid && bready && s.bresp == cpu_regs_pkg::RESP_OKAY);
endmodule

// ### core/cpu_regs_pkg.sv
// package: register file types, flag layout, memory map and bus map
package cpu_regs_pkg;
	localparam int FLAG_W = 11;
	localparam int FLG_C = 0;
	localparam int FLG_D = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_S = 3;
	localparam int FLG_B = 4;
	localparam int FLG_O = 5;
	localparam int FLG_I = 6;
	localparam int FLG_U = 7;
	localparam int FLG_PRIO = 8;
	localparam logic [5:0] SWI_USER_LIMIT = 6'h20;
	localparam logic [19:0] SFR_END   = 20'h002FF;
	localparam logic [19:0] RAM_BASE  = 20'h00400;
	localparam logic [19:0] SFR2_BASE = 20'h01300;
	localparam logic [19:0] SFR2_END  = 20'h0147F;
	localparam logic [19:0] VECT_BASE = 20'h0FFDC;
	localparam logic [19:0] ROM_TOP   = 20'h0FFFF;
	localparam logic [5:0] AX_BANK1  = 6'h08;
	localparam logic [5:0] AX_VTB    = 6'h10;
	localparam logic [5:0] AX_PROG   = 6'h11;
	localparam logic [5:0] AX_USP    = 6'h12;
	localparam logic [5:0] AX_ISP    = 6'h13;
	localparam logic [5:0] AX_STATIC = 6'h14;
	localparam logic [5:0] AX_FLAGS  = 6'h15;
	localparam logic [2:0] SLOT_ADDR  = 3'h4;
	localparam logic [2:0] SLOT_FRAME = 3'h6;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3, SEL_ADDR0, SEL_ADDR1,
		SEL_FRAME, SEL_VTB, SEL_PROG, SEL_USP, SEL_ISP, SEL_STATIC,
		SEL_FLAGS, SEL_SP
	} regSel_t;
	typedef enum logic [1:0] {SZ_LO, SZ_HI, SZ_WORD, SZ_LONG} opSize_t;
	typedef enum logic [2:0] {
		REGION_SFR, REGION_RAM, REGION_ROM, REGION_VECT, REGION_NONE
	} region_t;

	typedef struct packed {
		logic        en;
		regSel_t     sel;
		opSize_t     size;
		logic [31:0] data;
	} regWr_t;
	typedef struct packed {
		logic        en;
		opSize_t     size;
		logic [31:0] result;
		logic        carry;
		logic        ovf;
	} aluFlags_t;
	typedef struct packed {
		logic       req;
		logic [2:0] level;
		logic       maskable;
	} intReq_t;
	typedef struct packed {
		logic [3:0][15:0] data;
		logic [1:0][15:0] addr;
		logic [15:0]      frame;
	} bank_t;
	typedef struct packed {
		bank_t [1:0]       bank;
		logic [19:0]       vtb;
		logic [19:0]       prog;
		logic [15:0]       user_stack_ptr;
		logic [15:0]       irq_stack_ptr;
		logic [15:0]       stat;
		logic [FLAG_W-1:0] flags;
		logic              awHeld;
		logic [7:0]        awAddr;
		logic              wHeld;
		logic [31:0]       wData;
		logic [3:0]        wStrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_t;
endpackage

// ### tb/cpu_register_file_tb_top.sv
// self-checking bench for the cpu register file
`timescale 1ns/1ns
module cpu_register_file_tb_top;
	localparam logic [1:0] OK = cpu_regs_pkg::RESP_OKAY;
	localparam logic [1:0] ER = cpu_regs_pkg::RESP_SLVERR;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	cpu_regs_pkg::regWr_t    wrIn;
	cpu_regs_pkg::aluFlags_t aluIn;
	cpu_regs_pkg::intReq_t   irqIn = '0;
	cpu_regs_pkg::regSel_t   rdSel = cpu_regs_pkg::SEL_DATA0;
	cpu_regs_pkg::opSize_t   rdSize = cpu_regs_pkg::SZ_WORD;
	cpu_regs_pkg::region_t   memRegion, fetchRegion;
	logic                    hwAck, swIntAck, irqTake;
	logic [5:0]              swIntNum;
	logic [19:0]             memAddr = '0;
	logic [31:0]             rdData, rdata;
	logic [10:0]             flagsOut;
	logic [15:0]             activeSp;
	logic [19:0]             progOut, vtbOut;
	logic [7:0]              awaddr = '0;
	logic [7:0]              araddr = '0;
	logic [31:0]             wdata = '0;
	logic                    awvalid = 1'b0;
	logic                    wvalid = 1'b0;
	logic                    arvalid = 1'b0;
	logic                    awready, wready, bvalid, arready, rvalid;
	logic [1:0]              bresp, rresp;
	int                      n_errors = 0;
	int                      tests_run = 0;
	int                      m [22];
	logic [19:0]             ra [14] = '{20'h00000, 20'h002FF, 20'h00400, 20'h00DFF,
		20'h00E00, 20'h01300, 20'h0147F, 20'h04000, 20'h0FFDB, 20'h0FFDC,
		20'h0FFFF, 20'h10000, 20'hFFFFF, 20'h03FFF};
	// region codes in enum order: sfr ram rom vect none
	int                      rr [14] = '{0, 0, 1, 1, 4, 0, 0, 2, 2, 3, 3, 4, 4, 4};

	always #20 clk = ~clk;

	// response ready lines held high: any answer is taken at once
	cpu_register_file i_cpu_register_file (.clk(clk), .rst_n(rst_n), .wrIn(wrIn),
		.rdSel(rdSel), .rdSize(rdSize), .rdData(rdData), .aluIn(aluIn), .irqIn(irqIn),
		.irqTake(irqTake), .hwAck(hwAck), .swIntAck(swIntAck), .swIntNum(swIntNum),
		.memAddr(memAddr), .memRegion(memRegion), .fetchRegion(fetchRegion),
		.flagsOut(flagsOut), .activeSp(activeSp), .progOut(progOut), .vtbOut(vtbOut),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1));

	exec_model i_exec_model (.clk(clk), .wrIn(wrIn), .aluIn(aluIn), .hwAck(hwAck),
		.swIntAck(swIntAck), .swIntNum(swIntNum));

	function automatic logic [31:0] msk(input int i);
		return (i == 16 || i == 17) ? 32'h000FFFFF : (i == 21) ? 32'h000007FF : 32'h0000FFFF;
	endfunction

	task automatic close_out();
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask

	// handshake lines are read mid-cycle, the values the next rising edge samples
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int         n;
		logic       aw;
		logic       w;
		logic       b;
		logic [1:0] rs;
		n = 0;
		b = 1'b0;
		rs = 2'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!b && n < 40) begin
			@(negedge clk);
			aw = awready;
			w = wready;
			b = bvalid;
			rs = bresp;
			@(posedge clk);
			n++;
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
		end
		if (!b) begin
			n_errors++;
			close_out();
		end
		chk("bresp", 32'(er), 32'(rs));
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int          n;
		logic        ar;
		logic        v;
		logic [1:0]  rs;
		logic [31:0] rd;
		n = 0;
		v = 1'b0;
		rs = 2'h0;
		rd = 32'h00000000;
		araddr <= a;
		arvalid <= 1'b1;
		while (!v && n < 40) begin
			@(negedge clk);
			ar = arready;
			v = rvalid;
			rs = rresp;
			rd = rdata;
			@(posedge clk);
			n++;
			if (ar)
				arvalid <= 1'b0;
		end
		if (!v) begin
			n_errors++;
			close_out();
		end
		chk("rresp", 32'(er), 32'(rs));
		chk("rdata", e, rd);
	endtask

	task automatic setf(input logic [31:0] v);
		m[21] = v;
		axw(8'h54, v, OK);
	endtask

	task automatic probe(input cpu_regs_pkg::regSel_t s, input cpu_regs_pkg::opSize_t z,
			input logic [31:0] e);
		rdSel <= s;
		rdSize <= z;
		@(negedge clk);
		chk("rdData", e, rdData);
		@(posedge clk);
	endtask

	initial begin
		int i, b, l, k, q;
		logic [31:0] r;
		q = $urandom(32'hD8896817);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (i = 0; i < 22; i++) begin
			if (i == 7 || i == 15) continue;
			axr(8'(i * 4), 32'h0, OK);
			r = $urandom;
			if (i == 21) r[1] = 1'b0;
			m[i] = r & msk(i);
			axw(8'(i * 4), r, OK);
			axr(8'(i * 4), m[i], OK);
		end
		axw(8'h58, 32'hFFFFFFFF, ER);
		axr(8'h58, 32'h0, ER);
		for (b = 0; b < 2; b++) begin
			setf(32'(b << 4));
			l = 8 * b;
			probe(cpu_regs_pkg::SEL_DATA0, cpu_regs_pkg::SZ_WORD, m[l]);
			probe(cpu_regs_pkg::SEL_DATA0, cpu_regs_pkg::SZ_HI, (m[l] >> 8) & 255);
			probe(cpu_regs_pkg::SEL_DATA1, cpu_regs_pkg::SZ_LO, m[l + 1] & 255);
			probe(cpu_regs_pkg::SEL_DATA0, cpu_regs_pkg::SZ_LONG, (m[l + 2] << 16) | m[l]);
			probe(cpu_regs_pkg::SEL_DATA1, cpu_regs_pkg::SZ_LONG,
				(m[l + 3] << 16) | m[l + 1]);
			probe(cpu_regs_pkg::SEL_ADDR0, cpu_regs_pkg::SZ_LONG,
				(m[l + 5] << 16) | m[l + 4]);
			probe(cpu_regs_pkg::SEL_FRAME, cpu_regs_pkg::SZ_WORD, m[l + 6]);
		end
		r = $urandom;
		i_exec_model.wr(cpu_regs_pkg::SEL_DATA3, r);
		m[11] = r & 32'hFFFF;
		axr(8'h2C, m[11], OK);
		axr(8'h0C, m[3], OK);
		r = $urandom;
		i_exec_model.wr(cpu_regs_pkg::SEL_DATA0, r);
		m[8] = r & 32'hFFFF;
		axr(8'h20, m[8], OK);
		setf(32'h0);
		for (k = 0; k < 8; k++) begin
			r = (k == 0) ? 32'h0 : k[2] ? $urandom : ($urandom & 32'hFFFF);
			i_exec_model.alu(r, k[0], k[1],
				k[2] ? cpu_regs_pkg::SZ_LONG : cpu_regs_pkg::SZ_WORD);
			m[21] = k[0] | ((r == 0) << 2) | ((k[2] ? r[31] : r[15]) << 3) | (k[1] << 5);
			axr(8'h54, m[21], OK);
		end
		for (b = 0; b < 8; b++) begin
			setf(32'((b << 8) | ((b & 1) << 6)));
			for (l = 0; l < 16; l++) begin
				irqIn <= '{1'b1, 3'(l >> 1), l[0]};
				@(negedge clk);
				chk("irqTake", ((l >> 1) > b) && (b[0] || !l[0]), irqTake);
				@(posedge clk);
			end
		end
		irqIn <= '0;
		for (k = 0; k < 3; k++) begin
			setf(32'hC0);
			@(negedge clk);
			chk("activeSp", m[18], activeSp);
			@(posedge clk);
			i_exec_model.ack(k == 0, k != 0, 6'(30 + k));
			@(negedge clk);
			chk("flagsOut", (k == 2) ? 32'h80 : 32'h0, flagsOut);
			chk("activeSp", (k == 2) ? m[18] : m[19], activeSp);
			@(posedge clk);
		end
		r = $urandom;
		i_exec_model.wr(cpu_regs_pkg::SEL_SP, r);
		@(negedge clk);
		chk("activeSp", r & 32'hFFFF, activeSp);
		@(posedge clk);
		for (i = 0; i < 14; i++) begin
			memAddr <= ra[i];
			@(negedge clk);
			chk("memRegion", rr[i], 32'(memRegion));
			@(posedge clk);
		end
		axw(8'h44, 32'h0FFDC, OK);
		@(negedge clk);
		chk("progOut", 32'h0FFDC, progOut);
		chk("fetchRegion", 3, 32'(fetchRegion));
		chk("vtbOut", m[16], vtbOut);
		close_out();
	end
endmodule

// ### tb/exec_model.sv
// execution unit stand-in: register writes, alu flag updates, acknowledges
`timescale 1ns/1ns
module exec_model (
	input  wire logic                    clk,      // core clock
	output cpu_regs_pkg::regWr_t         wrIn,     // register write
	output cpu_regs_pkg::aluFlags_t      aluIn,    // flag update
	output logic                         hwAck,    // hardware acknowledge
	output logic                         swIntAck, // software interrupt
	output logic [5:0]                   swIntNum  // software number
);
	initial begin
		wrIn = '0;
		aluIn = '0;
		hwAck = 1'b0;
		swIntAck = 1'b0;
		swIntNum = 6'h00;
	end

	// one-cycle strobe, then a spare edge so calls never collide
	task automatic idle();
		@(posedge clk);
		wrIn <= '0;
		aluIn <= '0;
		hwAck <= 1'b0;
		swIntAck <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input cpu_regs_pkg::regSel_t s, input logic [31:0] d);
		wrIn <= '{1'b1, s, cpu_regs_pkg::SZ_WORD, d};
		idle();
	endtask

	task automatic alu(input logic [31:0] r, input logic c, input logic o,
		input cpu_regs_pkg::opSize_t z);
		aluIn <= '{1'b1, z, r, c, o};
		idle();
	endtask

	task automatic ack(input logic h, input logic s, input logic [5:0] n);
		hwAck <= h;
		swIntAck <= s;
		swIntNum <= n;
		idle();
	endtask
endmodule
